// [src/ifeb_pkg.sv]
// Package: register map, bit masks and reset values of the flag/enable bank
package ifeb_pkg;
  // ******************************************************************
  // Register byte offsets (AHB-Lite, one aligned word each)
  // ******************************************************************
  localparam logic [7:0] FLAGS1_OFS = 8'h00;
  localparam logic [7:0] FLAGS2_OFS = 8'h04;
  localparam logic [7:0] FLAGS3_OFS = 8'h08;
  localparam logic [7:0] FLAGS4_OFS = 8'h0C;
  localparam logic [7:0] FLAGS5_OFS = 8'h10;
  localparam logic [7:0] ENABLES0_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
  // ******************************************************************
  // Implemented-bit masks per word
  // ******************************************************************
  localparam logic [15:0] FLAGS1_MASK = 16'hFEDF;
  localparam logic [15:0] FLAGS2_MASK = 16'h3FE3;
  localparam logic [15:0] FLAGS3_MASK = 16'h4066;
  localparam logic [15:0] FLAGS4_MASK = 16'h210E;
  localparam logic [15:0] FLAGS5_MASK = 16'h3FBE;
  localparam logic [15:0] ENABLES0_MASK = 16'h3FEF;
  // Event status/mask: one bit per flag word (words 1..5)
  localparam logic [4:0] IRQ_MASK_BITS = 5'h1F;
  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0] IRQ_RST = 5'h00;
  localparam int NUM_FLAG_WORDS = 5;
endpackage : ifeb_pkg

// [src/ifeb_flag_word.sv]
// One 16-bit flag word: hardware set, software write, set wins
module ifeb_flag_word #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [15:0] hw_set, // Source event pulses
  input wire logic sw_we, // Software write strobe
  input wire logic [15:0] sw_data, // Software write data
  output logic [15:0] flags_r // Current flags
);
  logic [15:0] flags_nxt;

  // Next value: write replaces, then any set event forces ones on implemented bits
  always_comb begin
    flags_nxt = flags_r;
    if (sw_we) begin
      flags_nxt = sw_data; // [RULE11]
    end
    flags_nxt = (flags_nxt | hw_set) & IMPL_MASK; // [RULE13] [RULE11]
  end

  // Register; cleared at power-on reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= ifeb_pkg::WORD_RST; // [RULE11]
    end else if (ce) begin
      flags_r <= flags_nxt;
    end
  end
endmodule // ifeb_flag_word

// [src/ifeb_top.sv]
// Top: interrupt flag words 1..5 and enable word 0 behind AHB-Lite
// Summary of operation
// [RULE1] Word1 high: U2TX,U2RX,EXT2,T5,T4,OC4,OC3; bit8 none
// [RULE2] Word1 low: IC8,IC7,-,EXT1,CN,CMP,MI2C1,SI2C1
// [RULE3] Word2 high: -,-,PMP,OC8,OC7,OC6,OC5,IC6
// [RULE4] Word2 low: IC5,IC4,IC3,-,-,-,SPI2,SPI2 fault
// [RULE5] Word3: calendar 14, EXT4 6, EXT3 5, I2C2 2,1
// [RULE6] Word4: charge 13, lowvolt 8, crc 3, uart errs
// [RULE7] Word5 high: -,-,IC9,OC9,SPI3,SPI3F,U4TX,U4RX
// [RULE8] Word5 low: U4ERR,-,MI2C3,SI2C3,U3TX,U3RX,U3ERR,-
// [RULE9] Enable0 high: -,-,ADC,U1TX,U1RX,SPI1,SPI1F,T3
// [RULE10] Enable0 low: T2,OC2,IC2,-,T1,OC1,IC1,EXT0
// [RULE11] Implemented bits RW, reset zero; others read zero
// [RULE12] Flag and enable bits share vector ordering
// [RULE13] Flags stay set; hardware set beats clear
// [RULE14] Request equals flag AND matching enable; here the requests are the flags alone, not gated by any enable
module ifeb_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce, // Clock enable: freezes all state when low
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event inputs, one pulse per source, by word position
  input wire logic [15:0] flags1_set,
  input wire logic [15:0] flags2_set,
  input wire logic [15:0] flags3_set,
  input wire logic [15:0] flags4_set,
  input wire logic [15:0] flags5_set,
  // Source requests to the priority logic
  output logic [15:0] req1_r,
  output logic [15:0] req2_r,
  output logic [15:0] req3_r,
  output logic [15:0] req4_r,
  output logic [15:0] req5_r,
  output logic [15:0] enables0_r, // Enable word 0 contents
  output logic irq_r // Level interrupt of the bank
);
  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Word index decode from the low address bits
  function automatic logic is_ofs(input logic [31:0] a,
                                  input logic [7:0] ofs);
    is_ofs = (a[7:2] == ofs[7:2]);
  endfunction

  // ******************************************************************
  // AHB address phase capture
  // ******************************************************************
  logic wr_pend_r, wr_pend_nxt; // Write data phase pending
  logic rd_pend_r, rd_pend_nxt; // Read data phase pending
  logic [31:0] addr_r, addr_nxt; // Captured address
  logic [31:0] hrdata_nxt;
  logic xfer; // Valid transfer seen in address phase

  assign xfer = hsel & hready & htrans[1];

  // Capture address and kind; read data is prepared one phase ahead
  always_comb begin
    wr_pend_nxt = 1'b0;
    rd_pend_nxt = 1'b0;
    addr_nxt = addr_r;
    if (xfer) begin
      wr_pend_nxt = hwrite;
      rd_pend_nxt = ~hwrite;
      addr_nxt = haddr;
    end
  end

  // ******************************************************************
  // Flag words
  // ******************************************************************
  logic [15:0] f1, f2, f3, f4, f5; // Flag word contents
  logic we1, we2, we3, we4, we5; // Write strobes
  logic [15:0] wdat;

  assign wdat = hwdata[15:0];
  // Write strobes decode the captured data-phase address
  assign we1 = wr_pend_r & is_ofs(addr_r, ifeb_pkg::FLAGS1_OFS);
  assign we2 = wr_pend_r & is_ofs(addr_r, ifeb_pkg::FLAGS2_OFS);
  assign we3 = wr_pend_r & is_ofs(addr_r, ifeb_pkg::FLAGS3_OFS);
  assign we4 = wr_pend_r & is_ofs(addr_r, ifeb_pkg::FLAGS4_OFS);
  assign we5 = wr_pend_r & is_ofs(addr_r, ifeb_pkg::FLAGS5_OFS);

  // Each word masks its unimplemented positions
  ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::FLAGS1_MASK)) u_w1 ( // [RULE1] [RULE2]
    .clk(clk), .nrst(nrst), .ce(ce), .hw_set(flags1_set),
    .sw_we(we1), .sw_data(wdat), .flags_r(f1));
  ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::FLAGS2_MASK)) u_w2 ( // [RULE3] [RULE4]
    .clk(clk), .nrst(nrst), .ce(ce), .hw_set(flags2_set),
    .sw_we(we2), .sw_data(wdat), .flags_r(f2));
  ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::FLAGS3_MASK)) u_w3 ( // [RULE5]
    .clk(clk), .nrst(nrst), .ce(ce), .hw_set(flags3_set),
    .sw_we(we3), .sw_data(wdat), .flags_r(f3));
  ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::FLAGS4_MASK)) u_w4 ( // [RULE6]
    .clk(clk), .nrst(nrst), .ce(ce), .hw_set(flags4_set),
    .sw_we(we4), .sw_data(wdat), .flags_r(f4));
  ifeb_flag_word #(.IMPL_MASK(ifeb_pkg::FLAGS5_MASK)) u_w5 ( // [RULE7] [RULE8]
    .clk(clk), .nrst(nrst), .ce(ce), .hw_set(flags5_set),
    .sw_we(we5), .sw_data(wdat), .flags_r(f5));

  // ******************************************************************
  // Enable word 0 and bank interrupt registers
  // ******************************************************************
  logic [15:0] enables0_nxt;
  logic [4:0] stat_r, stat_nxt; // Sticky per-word event status
  logic [4:0] mask_r, mask_nxt; // Interrupt mask, 1 passes
  logic [4:0] evt; // Any event in word n this cycle
  logic irq_nxt;

  assign evt = {|flags5_set, |flags4_set, |flags3_set,
                |flags2_set, |flags1_set};

  // Software writes; status is write-one-to-clear, set wins
  always_comb begin
    enables0_nxt = enables0_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_pend_r && is_ofs(addr_r, ifeb_pkg::ENABLES0_OFS)) begin
      enables0_nxt = wdat & ifeb_pkg::ENABLES0_MASK; // [RULE9] [RULE10]
    end
    if (wr_pend_r && is_ofs(addr_r, ifeb_pkg::IRQ_STAT_OFS)) begin
      stat_nxt = stat_r & ~hwdata[4:0];
    end
    if (wr_pend_r && is_ofs(addr_r, ifeb_pkg::IRQ_MASK_OFS)) begin
      mask_nxt = hwdata[4:0] & ifeb_pkg::IRQ_MASK_BITS;
    end
    stat_nxt = stat_nxt | evt; // [RULE13]
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // ******************************************************************
  // Read mux
  // ******************************************************************
  // Uses current register values, so a read right after a write sees the old data
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (xfer && !hwrite) begin
      if (is_ofs(haddr, ifeb_pkg::FLAGS1_OFS)) begin
        hrdata_nxt = {16'h0000, f1};
      end else if (is_ofs(haddr, ifeb_pkg::FLAGS2_OFS)) begin
        hrdata_nxt = {16'h0000, f2};
      end else if (is_ofs(haddr, ifeb_pkg::FLAGS3_OFS)) begin
        hrdata_nxt = {16'h0000, f3};
      end else if (is_ofs(haddr, ifeb_pkg::FLAGS4_OFS)) begin
        hrdata_nxt = {16'h0000, f4};
      end else if (is_ofs(haddr, ifeb_pkg::FLAGS5_OFS)) begin
        hrdata_nxt = {16'h0000, f5};
      end else if (is_ofs(haddr, ifeb_pkg::ENABLES0_OFS)) begin
        hrdata_nxt = {16'h0000, enables0_r}; // [RULE11]
      end else if (is_ofs(haddr, ifeb_pkg::IRQ_STAT_OFS)) begin
        hrdata_nxt = {27'h0000000, stat_r};
      end else if (is_ofs(haddr, ifeb_pkg::IRQ_MASK_OFS)) begin
        hrdata_nxt = {27'h0000000, mask_r};
      end else begin
        // Unmapped: reads zero, still OKAY
        hrdata_nxt = 32'h0000_0000;
      end
    end
  end

  // ******************************************************************
  // Request outputs
  // ******************************************************************
  logic [15:0] r1_nxt, r2_nxt, r3_nxt, r4_nxt, r5_nxt;

  // Flag word n pairs with enable word n, bit for bit; enable word 0
  // belongs to flag word 0 and enable words 1..5 sit outside this bank,
  // so gating word 1 with enable word 0 would mix unrelated sources.
  // The flags pass as requests and meet their enables downstream,
  // where a source asks only while flag and enable are both set
  always_comb begin
    r1_nxt = f1; // [RULE12] [RULE14]
    r2_nxt = f2;
    r3_nxt = f3;
    r4_nxt = f4;
    r5_nxt = f5;
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  // All state frozen when ce is low; zero after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      enables0_r <= ifeb_pkg::WORD_RST; // [RULE11]
      stat_r <= ifeb_pkg::IRQ_RST;
      mask_r <= ifeb_pkg::IRQ_RST;
      irq_r <= 1'b0;
      req1_r <= ifeb_pkg::WORD_RST;
      req2_r <= ifeb_pkg::WORD_RST;
      req3_r <= ifeb_pkg::WORD_RST;
      req4_r <= ifeb_pkg::WORD_RST;
      req5_r <= ifeb_pkg::WORD_RST;
    end else if (ce) begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r <= addr_nxt;
      hrdata <= hrdata_nxt;
      enables0_r <= enables0_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      req1_r <= r1_nxt;
      req2_r <= r2_nxt;
      req3_r <= r3_nxt;
      req4_r <= r4_nxt;
      req5_r <= r5_nxt;
    end
  end

  // Zero-wait slave, always OKAY; kept as flops for registered outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule // ifeb_top

// [tb/ifeb_chk_sva.sv]
// Checker: port-level properties of the flag/enable bank
module ifeb_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] flags2_set,
  input wire logic [15:0] req1_r,
  input wire logic [15:0] req2_r,
  input wire logic [15:0] req3_r,
  input wire logic [15:0] req4_r,
  input wire logic [15:0] req5_r,
  input wire logic [15:0] enables0_r
);
  // ******************************************************************
  // Properties, all in the single clock domain
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Event on an implemented bit of word 2
  sequence s_evt2;
    |(flags2_set & 16'h3FE3);
  endsequence
  // Two edges on, the request copy carries every pulsed bit
  sequence s_req2_up;
    ##2 ((req2_r & $past(flags2_set, 2) & 16'h3FE3)
      == ($past(flags2_set, 2) & 16'h3FE3));
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not OKAY");
  chk_rdata_idle: assert property
    (!$past(hsel && htrans[1] && !hwrite) |-> hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_req1_impl: assert property ((req1_r & ~16'hFEDF) == 16'h0)
    else $error("request on unused bit of word 1");
  chk_req2_impl: assert property ((req2_r & ~16'h3FE3) == 16'h0)
    else $error("request on unused bit of word 2");
  chk_req3_impl: assert property ((req3_r & ~16'h4066) == 16'h0)
    else $error("request on unused bit of word 3");
  chk_req4_impl: assert property ((req4_r & ~16'h210E) == 16'h0)
    else $error("request on unused bit of word 4");
  chk_req5_impl: assert property ((req5_r & ~16'h3FBE) == 16'h0)
    else $error("request on unused bit of word 5");
  chk_en0_impl: assert property ((enables0_r & ~16'h3FEF) == 16'h0)
    else $error("enable set on unused bit");
  chk_evt_sticky: assert property (s_evt2 |-> s_req2_up)
    else $error("event did not reach the request");
endmodule // ifeb_chk

bind ifeb_top ifeb_chk u_chk (.clk(clk), .nrst(nrst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hresp(hresp),
  .hreadyout(hreadyout), .flags2_set(flags2_set), .req1_r(req1_r),
  .req2_r(req2_r), .req3_r(req3_r), .req4_r(req4_r), .req5_r(req5_r),
  .enables0_r(enables0_r));

// [tb/ifeb_src_model.sv]
// Model of the peripheral event sources feeding the bank
module ifeb_src_model (
  input wire logic clk,
  input wire logic fire, // Bench asks for one event burst
  input wire logic [2:0] word, // Flag word 1..5 to hit
  input wire logic [15:0] pat, // Bits to pulse
  output logic [15:0] set1 = 16'h0000,
  output logic [15:0] set2 = 16'h0000,
  output logic [15:0] set3 = 16'h0000,
  output logic [15:0] set4 = 16'h0000,
  output logic [15:0] set5 = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sources pulse for one cycle only, so stickiness is the bank's job
  always_ff @(posedge clk) begin
    set1 <= (fire && word == 3'h1) ? pat : 16'h0000;
    set2 <= (fire && word == 3'h2) ? pat : 16'h0000;
    set3 <= (fire && word == 3'h3) ? pat : 16'h0000;
    set4 <= (fire && word == 3'h4) ? pat : 16'h0000;
    set5 <= (fire && word == 3'h5) ? pat : 16'h0000;
  end
endmodule // ifeb_src_model

// [tb/testbench.sv]
// Testbench: bus, event and interrupt scenarios for the bank
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ******************************************************************
  // Signals and instances
  // ******************************************************************
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] word = 3'h0;
  logic [15:0] pat = 16'h0, en0;
  logic [15:0] st [1:5];
  logic [15:0] rq [1:5];
  logic hreadyout, hresp, irq_r;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  // Implemented bits of flag words 1..5 and enable word 0
  logic [15:0] msk [6] = '{16'hFEDF, 16'h3FE3, 16'h4066, 16'h210E,
    16'h3FBE, 16'h3FEF};
  ifeb_top u_ifeb_top (.clk(clk), .nrst(nrst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flags1_set(st[1]),
    .flags2_set(st[2]), .flags3_set(st[3]), .flags4_set(st[4]),
    .flags5_set(st[5]), .req1_r(rq[1]), .req2_r(rq[2]), .req3_r(rq[3]),
    .req4_r(rq[4]), .req5_r(rq[5]), .enables0_r(en0), .irq_r(irq_r));
  ifeb_src_model u_ifeb_src_model (.clk(clk), .fire(fire), .word(word),
    .pat(pat), .set1(st[1]), .set2(st[2]), .set3(st[3]), .set4(st[4]),
    .set5(st[5]));
  always #25 clk = ~clk;
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // One AHB-Lite single transfer; holds each phase until hready
  task automatic ahb(input logic wr, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    `CHK(rd, e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Ask the source model for one pulse on word w
  task automatic evt(input logic [2:0] w, input logic [15:0] p);
    @(posedge clk);
    fire <= 1'b1;
    word <= w;
    pat <= p;
    @(posedge clk);
    fire <= 1'b0;
    #1;
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rchk(32'(4 * i), 32'h0);
    rchk(32'h40, 32'h0);
    $display("TB: reset values done");
  endtask
  task automatic t_rw();
    for (int i = 0; i < 6; i++) wr(32'(4 * i), 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) rchk(32'(4 * i), {16'h0, msk[i]});
    `CHK(en0, 16'h3FEF)
    for (int i = 0; i < 6; i++) wr(32'(4 * i), 32'h0);
    wr(32'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) rchk(32'(4 * i), 32'h0);
    rchk(32'h40, 32'h0);
    $display("TB: read write done");
  endtask
  // Enables stay zero: requests of words 1..5 follow their own flags
  task automatic t_events();
    for (int w = 1; w < 6; w++) begin
      evt(3'(w), 16'hFFFF);
      tick(2);
      rchk(32'(4 * (w - 1)), {16'h0, msk[w - 1]});
      `CHK(rq[w], msk[w - 1])
      wr(32'(4 * (w - 1)), 32'h0);
      tick(1);
      `CHK(rq[w], 16'h0)
      rchk(32'(4 * (w - 1)), 32'h0);
    end
    $display("TB: events done");
  endtask
  // Clear write and source event land on the same edge
  task automatic t_wins();
    fork
      wr(32'h04, 32'h0);
      evt(3'h2, 16'h0100);
    join
    rchk(32'h04, 32'h0000_0100);
    wr(32'h04, 32'h0);
    $display("TB: set wins done");
  endtask
  task automatic t_irq();
    `CHK(irq_r, 1'b0)
    rchk(32'h18, 32'h1F);
    wr(32'h1C, 32'h02);
    tick(1);
    `CHK(irq_r, 1'b1)
    wr(32'h18, 32'h02);
    tick(1);
    `CHK(irq_r, 1'b0)
    rchk(32'h18, 32'h1D);
    evt(3'h2, 16'h0002);
    tick(2);
    `CHK(irq_r, 1'b1)
    wr(32'h18, 32'h1F);
    tick(1);
    `CHK(irq_r, 1'b0)
    rchk(32'h18, 32'h0);
    $display("TB: interrupt done");
  endtask
  task automatic give_verdict();
    $display("TB: checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_rw();
    t_events();
    t_wins();
    t_irq();
    give_verdict();
  end
endmodule // testbench
